// [rtl/ovt_pkg.sv]
// Shared constants, register map and carrier types of the overvoltage trip timer.
// Assumes a single 20 MHz clock and a 5 ms evaluation tick derived from it.
package ovt_pkg;
    // Clock and evaluation tick.
    localparam int CLK_HZ   = 20_000_000;
    localparam int TICK_MS  = 5;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

    // Register byte offsets.
    localparam int          ADDR_W  = 8;
    localparam logic [7:0]  A_CTRL  = 8'h00;
    localparam logic [7:0]  A_FIX   = 8'h04;
    localparam logic [7:0]  A_DIAL  = 8'h08;
    localparam logic [7:0]  A_EXPO  = 8'h0c;
    localparam logic [7:0]  A_REL   = 8'h10;
    localparam logic [7:0]  A_STAT  = 8'h14;
    localparam logic [7:0]  A_ISTAT = 8'h18;
    localparam logic [7:0]  A_IEN   = 8'h1c;
    localparam logic [7:0]  A_ICLR  = 8'h20;
    localparam logic [7:0]  A_OPCNT = 8'h24;

    // Control field positions; each field is a two-bit code.
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_REL_LSB  = 4;
    localparam int CTRL_TRS_LSB  = 8;
    localparam int CTRL_CON_LSB  = 12;

    // Setting codes.
    localparam logic [1:0] CODE_NO   = 2'h1;
    localparam logic [1:0] CODE_YES  = 2'h2;
    localparam logic [1:0] DTYPE_FIX = 2'h1;
    localparam logic [1:0] DTYPE_INV = 2'h2;

    // Setting widths.
    localparam int FIX_W  = 18;
    localparam int DIAL_W = 13;
    localparam int EXPO_W = 12;
    localparam int REL_W  = 15;
    localparam int CNT_W  = 32;
    localparam int RAT_W  = 16;
    localparam int PW_W   = 24;
    localparam int EV_W   = 3;

    // Defaults in their own units.
    localparam int FIX_DEF_MS   = 40;
    localparam int REL_DEF_MS   = 60;
    localparam int DIAL_DEF_CS  = 5;
    localparam int EXPO_DEF_HUN = 100;
    localparam int CS_MS        = 10;
    localparam int DIAL_MUL     = CS_MS / TICK_MS;

    localparam logic [FIX_W-1:0]  FIX_DEF  = FIX_W'(FIX_DEF_MS / TICK_MS);
    localparam logic [REL_W-1:0]  REL_DEF  = REL_W'(REL_DEF_MS / TICK_MS);
    localparam logic [DIAL_W-1:0] DIAL_DEF = DIAL_W'(DIAL_DEF_CS);
    localparam logic [EXPO_W-1:0] EXPO_DEF = EXPO_W'(EXPO_DEF_HUN);

    // Ratio is unsigned Q8.8; pick-up drops below 97 % of the threshold.
    localparam int               RESET_PCT  = 97;
    localparam logic [RAT_W-1:0] RATIO_ONE  = 16'h0100;
    localparam logic [RAT_W-1:0] RATIO_DROP = RAT_W'(256 * RESET_PCT / 100);

    // Division by 100 of the exponent, done as a multiply by 41 / 4096.
    localparam int EXP_SCALE_MUL = 41;

    // Interrupt event bits.
    localparam int EV_START = 0;
    localparam int EV_TRIP  = 1;
    localparam int EV_BLOCK = 2;

    typedef struct packed {
        logic [1:0]        con;
        logic [1:0]        trs;
        logic [1:0]        rel;
        logic [1:0]        dtype;
        logic [FIX_W-1:0]  fix;
        logic [DIAL_W-1:0] dial;
        logic [EXPO_W-1:0] expo;
        logic [REL_W-1:0]  rdly;
    } ovt_cfg_t;

    typedef struct packed {
        logic start;
        logic trip;
        logic blocked;
    } ovt_out_t;

    typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_TRIP, PH_REL} ovt_phase_t;
endpackage

// [rtl/ovt_pow.sv]
// Approximate excess term ratio^a - 1 for the inverse-time characteristic.
// Assumes ratio in Q8.8 and exponent in hundredths; result is Q16.8.
`timescale 1ns/1ps
module ovt_pow import ovt_pkg::*; (
    input  wire logic [RAT_W-1:0]  ratio,  // Measured over threshold.
    input  wire logic [EXPO_W-1:0] expo,   // Exponent, hundredths.
    output logic      [PW_W-1:0]   excess  // ratio^a - 1, Q16.8.
);
    logic [3:0]       msb;
    logic [RAT_W-1:0] norm;
    logic [10:0]      lg;
    logic [22:0]      prod;
    logic [28:0]      scl;
    logic [16:0]      e2;
    logic [8:0]       mant;

    // Piecewise-linear log2 and exp2 trade a few percent of accuracy for no
    // divider and no table.
    always_comb begin
        msb = 4'h0;
        for (int i = 0; i < RAT_W; i++) begin
            if (ratio[i]) begin
                msb = 4'(i);
            end
        end
        norm = ratio << (4'hf - msb);
        lg   = {3'(msb - 4'h8), norm[14:7]};
        prod = 23'(lg) * 23'(expo);
        scl  = 29'(prod) * 29'(EXP_SCALE_MUL);
        e2   = scl[28:12];
        mant = {1'b1, e2[7:0]};
        if (ratio <= RATIO_ONE) begin
            excess = '0;
        end else if (e2[16:8] >= 9'hf) begin
            excess = '1;
        end else begin
            excess = (PW_W'(mant) << e2[11:8]) - PW_W'(RATIO_ONE);
        end
    end
endmodule

// [rtl/ovt_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/1ps
module ovt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,    // Clock.
    input  wire logic             presetn, // Async reset, low.
    input  wire logic [WIDTH-1:0] din,     // Asynchronous input.
    output logic      [WIDTH-1:0] dout     // Filtered level.
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] dout_nxt;

    // A bit moves only once the second and third stages agree.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            dout_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : dout[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= dout_nxt;
        end
    end
endmodule

// [rtl/ovt_timer.sv]
// Overvoltage trip and release timer with an APB register file.
// Assumes ratio comes from logic on pclk and block_pin from outside.
//
// Notes on behaviour
// - instant setting trips together with start
// - fixed delay trips after continuous pick-up time
// - inverse time is dial over ratio^a minus one
// - delay type code 2 inverse, else fixed
// - fixed delay in 5 ms steps, 40 ms
// - zero fixed delay behaves as instant stage
// - time dial in 10 ms steps, 50 ms
// - exponent in hundredths, default one
// - release delay in 5 ms steps, 60 ms
// - delayed release holds start, else clears
// - counter clears after release or at drop
// - counting may continue through the release
// - no trip while pick-up is absent
// - defaults freeze counter for 60 ms release
// - block at pick-up reports blocked, no start
// - block during start acts as dropout
// - pick-up above threshold, drops below 97 %
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module ovt_timer import ovt_pkg::*; #(
    parameter int TICK = TICK_CYC
) (
    input  wire logic              pclk,      // Clock, 20 MHz.
    input  wire logic              presetn,   // Async reset, low.
    input  wire logic              psel,      // APB select.
    input  wire logic              penable,   // APB enable.
    input  wire logic              pwrite,    // APB write.
    input  wire logic [ADDR_W-1:0] paddr,     // APB byte address.
    input  wire logic [31:0]       pwdata,    // APB write data.
    output logic      [31:0]       prdata,    // APB read data.
    output logic                   pready,    // APB ready.
    output logic                   pslverr,   // APB error.
    input  wire logic [RAT_W-1:0]  ratio,     // Measured over threshold, Q8.8.
    input  wire logic              block_pin, // Block request pin.
    output logic                   start,     // Start output.
    output logic                   trip,      // Trip output.
    output logic                   blocked,   // Blocked output.
    output logic                   irq        // Interrupt level.
);
    localparam int TCW = $clog2(TICK + 1);
    localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK - 1);

    ovt_cfg_t             cfg_r;
    ovt_cfg_t             cfg_nxt;
    ovt_out_t             out_r;
    ovt_out_t             out_nxt;
    ovt_phase_t           ph_r;
    ovt_phase_t           ph_nxt;
    logic [TCW-1:0]       tcnt_r;
    logic [TCW-1:0]       tcnt_nxt;
    logic                 tick;
    logic                 pu_r;
    logic                 pu_nxt;
    logic [CNT_W-1:0]     op_r;
    logic [CNT_W-1:0]     op_nxt;
    logic [CNT_W-1:0]     op_step;
    logic [CNT_W:0]       op_sum;
    logic [CNT_W-1:0]     inc;
    logic [CNT_W-1:0]     lim_inv;
    logic [REL_W-1:0]     rel_r;
    logic [REL_W-1:0]     rel_nxt;
    logic [REL_W-1:0]     rel_cnt;
    logic                 expired;
    logic                 reach;
    logic                 active;
    logic                 blk;
    logic                 inv;
    logic [PW_W-1:0]      excess;
    logic [EV_W-1:0]      ist_r;
    logic [EV_W-1:0]      ist_nxt;
    logic [EV_W-1:0]      ien_r;
    logic [EV_W-1:0]      ien_nxt;
    logic [EV_W-1:0]      ev;
    logic [EV_W-1:0]      clr;
    logic [31:0]          rd_r;
    logic [31:0]          rd_nxt;
    logic                 bad_r;
    logic                 bad_nxt;
    logic                 wr;

    ovt_sync #(
        .WIDTH (1)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (block_pin),
        .dout    (blk)
    );

    ovt_pow u_pow (
        .ratio  (ratio),
        .expo   (cfg_r.expo),
        .excess (excess)
    );

    // Evaluation tick divider.
    always_comb begin
        tick     = (tcnt_r == '0);
        tcnt_nxt = tick ? TICK_LAST : tcnt_r - 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_r <= '0;
        end else begin
            tcnt_r <= tcnt_nxt;
        end
    end

    // Timing core, evaluated once per tick.
    always_comb begin
        inv     = (cfg_r.dtype == DTYPE_INV);
        inc     = inv ? CNT_W'(excess) : CNT_W'(1);
        // Operating time is k / (r^a - 1); integrating the excess per tick and
        // comparing with k lets the time follow a changing voltage.
        lim_inv = CNT_W'({cfg_r.dial, 8'h00}) * CNT_W'(DIAL_MUL);
        op_sum  = {1'b0, op_r} + {1'b0, inc};
        op_step = op_sum[CNT_W] ? '1 : op_sum[CNT_W-1:0];
        reach   = inv ? (op_step >= lim_inv) : (op_step >= CNT_W'(cfg_r.fix));
        pu_nxt  = pu_r;
        if (ratio > RATIO_ONE) begin
            pu_nxt = 1'b1;
        end else if (ratio < RATIO_DROP) begin
            pu_nxt = 1'b0;
        end
        active  = pu_nxt && !blk;
        rel_cnt = (ph_r == PH_REL) ? rel_r + 1'b1 : '0;
        expired = (rel_cnt >= cfg_r.rdly);
        ph_nxt  = ph_r;
        out_nxt = out_r;
        op_nxt  = op_r;
        rel_nxt = rel_r;
        if (tick) begin
            out_nxt.blocked = pu_nxt && blk;
            if (active) begin
                rel_nxt       = '0;
                out_nxt.start = 1'b1;
                if (ph_r != PH_TRIP) begin
                    op_nxt = op_step;
                    if (reach) begin
                        out_nxt.trip = 1'b1;
                        ph_nxt       = PH_TRIP;
                    end else begin
                        ph_nxt = PH_RUN;
                    end
                end
            end else begin
                case (ph_r)
                    PH_TRIP: begin
                        out_nxt.trip  = 1'b0;
                        out_nxt.start = 1'b0;
                        op_nxt        = '0;
                        ph_nxt        = PH_IDLE;
                    end
                    PH_RUN, PH_REL: begin
                        rel_nxt       = rel_cnt;
                        ph_nxt        = PH_REL;
                        out_nxt.start = (cfg_r.rel == CODE_YES) && !expired;
                        if (cfg_r.trs != CODE_YES) begin
                            op_nxt = '0;
                        end else if (cfg_r.con == CODE_YES) begin
                            op_nxt = op_step;
                        end
                        if (expired) begin
                            op_nxt = '0;
                            ph_nxt = PH_IDLE;
                        end
                    end
                    default: begin
                        out_nxt.start = 1'b0;
                        ph_nxt        = PH_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r  <= PH_IDLE;
            out_r <= '0;
            op_r  <= '0;
            rel_r <= '0;
            pu_r  <= 1'b0;
        end else begin
            ph_r  <= ph_nxt;
            out_r <= out_nxt;
            op_r  <= op_nxt;
            rel_r <= rel_nxt;
            pu_r  <= tick ? pu_nxt : pu_r;
        end
    end

    assign start   = out_r.start;
    assign trip    = out_r.trip;
    assign blocked = out_r.blocked;

    // Register file. Read data is captured in the setup cycle so the access
    // cycle can complete with no wait state.
    always_comb begin
        wr      = psel && penable && pwrite && !bad_r;
        cfg_nxt = cfg_r;
        ien_nxt = ien_r;
        clr     = '0;
        if (wr) begin
            case (paddr)
                A_CTRL: begin
                    cfg_nxt.dtype = pwdata[CTRL_TYPE_LSB+:2];
                    cfg_nxt.rel   = pwdata[CTRL_REL_LSB+:2];
                    cfg_nxt.trs   = pwdata[CTRL_TRS_LSB+:2];
                    cfg_nxt.con   = pwdata[CTRL_CON_LSB+:2];
                end
                A_FIX:   cfg_nxt.fix  = pwdata[FIX_W-1:0];
                A_DIAL:  cfg_nxt.dial = pwdata[DIAL_W-1:0];
                A_EXPO:  cfg_nxt.expo = pwdata[EXPO_W-1:0];
                A_REL:   cfg_nxt.rdly = pwdata[REL_W-1:0];
                A_IEN:   ien_nxt      = pwdata[EV_W-1:0];
                A_ICLR:  clr          = pwdata[EV_W-1:0];
                default: clr          = '0;
            endcase
        end
        ev[EV_START] = out_nxt.start && !out_r.start;
        ev[EV_TRIP]  = out_nxt.trip && !out_r.trip;
        ev[EV_BLOCK] = out_nxt.blocked && !out_r.blocked;
        // A new event outranks a clear in the same cycle.
        ist_nxt = (ist_r & ~clr) | ev;
        rd_nxt  = rd_r;
        bad_nxt = bad_r;
        if (psel && !penable) begin
            bad_nxt = 1'b0;
            case (paddr)
                A_CTRL: begin
                    rd_nxt = '0;
                    rd_nxt[CTRL_TYPE_LSB+:2] = cfg_r.dtype;
                    rd_nxt[CTRL_REL_LSB+:2] = cfg_r.rel;
                    rd_nxt[CTRL_TRS_LSB+:2] = cfg_r.trs;
                    rd_nxt[CTRL_CON_LSB+:2] = cfg_r.con;
                end
                A_FIX:   rd_nxt = 32'(cfg_r.fix);
                A_DIAL:  rd_nxt = 32'(cfg_r.dial);
                A_EXPO:  rd_nxt = 32'(cfg_r.expo);
                A_REL:   rd_nxt = 32'(cfg_r.rdly);
                A_STAT:  rd_nxt = {28'h0, pu_r, out_r.blocked, out_r.trip, out_r.start};
                A_ISTAT: rd_nxt = 32'(ist_r);
                A_IEN:   rd_nxt = 32'(ien_r);
                A_ICLR:  rd_nxt = '0;
                A_OPCNT: rd_nxt = op_r;
                default: begin
                    rd_nxt  = '0;
                    bad_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= '{con: CODE_NO, trs: CODE_YES, rel: CODE_YES, dtype: DTYPE_FIX,
                       fix: FIX_DEF, dial: DIAL_DEF, expo: EXPO_DEF, rdly: REL_DEF};
            ien_r <= '0;
            ist_r <= '0;
            rd_r  <= '0;
            bad_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            ien_r <= ien_nxt;
            ist_r <= ist_nxt;
            rd_r  <= rd_nxt;
            bad_r <= bad_nxt;
        end
    end

    assign prdata  = rd_r;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && bad_r;
    assign irq     = |(ist_r & ien_r);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_INSTANT: assert property (tick && !inv && cfg_r.fix == '0 && active && !trip |=> trip)
        else $error("zero fixed delay did not trip at once");
    AST_TOGETHER: assert property ($rose(start) && !inv && cfg_r.fix == '0 |-> trip)
        else $error("instant start came without trip");
    AST_FIX_REACH: assert property (tick && !inv && active && !trip
                                    && op_r + 1 >= CNT_W'(cfg_r.fix) |=> trip)
        else $error("fixed delay elapsed without trip");
    AST_FIX_EARLY: assert property (tick && !inv && active && !trip
                                    && op_r + 1 < CNT_W'(cfg_r.fix) |=> !trip)
        else $error("fixed delay tripped early");
    AST_INV_REACH: assert property (tick && inv && active && !trip
                                    && op_step >= lim_inv |=> trip)
        else $error("inverse time reached without trip");
    AST_BLOCKED: assert property (tick && pu_nxt && blk && !start |=> !start && blocked)
        else $error("blocked pick-up started timing");
    AST_BLK_DROP: assert property (tick && blk && start && !trip
                                   && cfg_r.rel != CODE_YES |=> !start)
        else $error("block did not release start");
    AST_NO_HOLD: assert property (tick && !active && !trip && cfg_r.rel != CODE_YES |=> !start)
        else $error("start held with delayed release off");
    AST_TRIP_CLR: assert property (tick && trip && !active |=> !trip && op_r == '0)
        else $error("trip not cleared with counter at dropout");
    AST_NO_REL_TRIP: assert property (tick && !active |=> !$rose(trip))
        else $error("trip raised without pick-up");
    AST_DROP_CLR: assert property (tick && !active && start && !trip
                                   && cfg_r.trs != CODE_YES |=> op_r == '0)
        else $error("counter not cleared at dropout");
    AST_FREEZE: assert property (tick && !active && ph_r == PH_REL && !expired
                                 && cfg_r.trs == CODE_YES && cfg_r.con != CODE_YES
                                 |=> $stable(op_r))
        else $error("counter moved during frozen release");
    AST_CONT: assert property (tick && !active && ph_r == PH_REL && !expired
                               && cfg_r.trs == CODE_YES && cfg_r.con == CODE_YES
                               |=> op_r == $past(op_step))
        else $error("counter did not continue during release");
    AST_TICK: assert property (tick |=> !tick || TICK == 1)
        else $error("tick lasted more than one cycle");
    // Between the two levels the pick-up keeps its last state, which is the hysteresis.
    AST_PU_SET: assert property (tick && ratio > RATIO_ONE |=> pu_r)
        else $error("pick-up did not set above threshold");
    AST_PU_DROP: assert property (tick && ratio < RATIO_DROP |=> !pu_r)
        else $error("pick-up held below reset ratio");
    AST_BLK_REPORT: assert property (tick && pu_nxt && blk |=> blocked)
        else $error("blocked pick-up not reported");
    AST_START_REL: assert property (tick && !active && start && !trip && !expired
                                    && cfg_r.rel == CODE_YES |=> start)
        else $error("start not held during release");
    AST_REL_END: assert property (tick && !active && ph_r == PH_REL && expired
                                  |=> !start && op_r == '0)
        else $error("release expiry left start or counter");

    COV_FIX_TRIP: cover property (tick && !inv && $rose(trip));
    COV_INV_TRIP: cover property (tick && inv && $rose(trip));
    COV_REL_END: cover property (ph_r == PH_REL ##1 ph_r == PH_IDLE);
    COV_BLOCKED: cover property ($rose(blocked));
    COV_CONT: cover property (tick && !active && ph_r == PH_REL && cfg_r.con == CODE_YES);
endmodule

// [sim/ovt_far.sv]
// Far-side model: the voltage comparator front end and the trip relay.
// Assumes one clock shared with the timer and a fixed threshold of THR units.
`timescale 1ns/1ps
module ovt_far import ovt_pkg::*; #(
    parameter int THR = 128
) (
    input  wire logic             pclk,             // Clock.
    input  wire logic             presetn,          // Async reset, low.
    input  wire logic [RAT_W-1:0] measured_voltage, // Measured level in the same units as THR.
    input  wire logic             trip,             // Trip from the timer.
    output logic      [RAT_W-1:0] ratio,            // Measured over threshold, Q8.8.
    output logic                  relay             // Relay contact state.
);
    // The ratio is registered so that it only moves just after a clock edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio <= '0;
            relay <= 1'b0;
        end else begin
            ratio <= RAT_W'((32'(measured_voltage) << 8) / THR);
            relay <= trip;
        end
    end
endmodule

// [sim/ovt_timer_bench.sv]
// Self-checking bench of the overvoltage trip timer.
// Assumes ovt_far feeds the ratio and the tick is shortened to TK cycles.
`timescale 1ns/1ps
module ovt_timer_bench import ovt_pkg::*;;
    localparam int TK = 8;
    typedef struct {
        logic [15:0] ctrl;
        logic [17:0] fix;
        logic [15:0] mv;
        logic        blk;
        int          n;
        logic [2:0]  exp;
    } ovt_row_t;
    logic              pclk, presetn, psel, penable, pwrite, block_pin;
    logic              pready, pslverr, start, trip, blocked, irq, relay, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [RAT_W-1:0]  ratio, mv;
    int                err_count, checks_done;
    int                cyc = 0;
    logic [7:0]        ra [5] = '{A_CTRL, A_FIX, A_DIAL, A_EXPO, A_REL};
    logic [31:0]       rv [5] = '{32'h1221, 32'h8, 32'h5, 32'h64, 32'hc};
    ovt_row_t          rows [8] = '{
        '{16'h1221, 18'h8, 16'h90, 1'b0, 1, 3'b100},
        '{16'h1221, 18'h8, 16'h90, 1'b0, 7, 3'b100},
        '{16'h1221, 18'h8, 16'h90, 1'b0, 8, 3'b110},
        '{16'h1221, 18'h0, 16'h90, 1'b0, 1, 3'b110},
        '{16'h1221, 18'h8, 16'h90, 1'b1, 2, 3'b001},
        '{16'h1221, 18'h8, 16'h7e, 1'b0, 3, 3'b000},
        '{16'h1222, 18'h8, 16'h100, 1'b0, 8, 3'b100},
        '{16'h1222, 18'h8, 16'h100, 1'b0, 11, 3'b110}
    };

    ovt_timer #(.TICK(TK)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ratio, .block_pin, .start, .trip, .blocked, .irq);
    ovt_far far (.pclk, .presetn, .measured_voltage(mv), .trip, .ratio, .relay);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            give_verdict();
        end
    endtask

    // Waits n evaluation ticks, then one edge more so the outputs read are settled.
    task automatic tk(input int n);
        int w;
        repeat (n) begin
            w = 0;
            do begin
                @(posedge pclk);
                w++;
            end while (cyc % TK != 0 && w < 2 * TK);
            if (w >= 2 * TK) begin
                err_count++;
                give_verdict();
            end
        end
        @(posedge pclk);
    endtask

    task automatic idle;
        mv <= '0;
        block_pin <= 1'b0;
        tk(16);
    endtask

    task automatic setup(input logic [31:0] c);
        apb(1'b1, A_CTRL, c);
        apb(1'b1, A_FIX, 32'h8);
        tk(1);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, block_pin} = '0;
        paddr = '0;
        pwdata = '0;
        mv = '0;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset value", rd, rv[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        $display("register test done");
        foreach (rows[i]) begin
            apb(1'b1, A_CTRL, 32'(rows[i].ctrl));
            apb(1'b1, A_FIX, 32'(rows[i].fix));
            tk(1);
            mv <= rows[i].mv;
            block_pin <= rows[i].blk;
            tk(rows[i].n);
            chk("outputs", {start, trip, blocked}, rows[i].exp);
            idle();
            $display("row %0d done", i);
        end
        setup(32'h1221);
        apb(1'b1, A_ICLR, 32'h7);
        apb(1'b1, A_IEN, 32'h2);
        tk(1);
        mv <= 16'h90;
        tk(4);
        chk("irq masked", irq, 1'b0);
        mv <= '0;
        tk(5);
        chk("start held", start, 1'b1);
        mv <= 16'h90;
        tk(3);
        chk("trip early", trip, 1'b0);
        tk(1);
        chk("trip resumed", trip, 1'b1);
        chk("irq", irq, 1'b1);
        apb(1'b0, A_ISTAT, 32'h0);
        chk("relay", relay, 1'b1);
        chk("event status", rd, 32'h3);
        apb(1'b1, A_ICLR, 32'h2);
        tk(1);
        chk("irq cleared", irq, 1'b0);
        mv <= '0;
        tk(1);
        chk("trip drop", {start, trip}, 2'b00);
        mv <= 16'h90;
        tk(7);
        chk("counter cleared", trip, 1'b0);
        idle();
        tk(1);
        mv <= 16'h90;
        tk(2);
        mv <= '0;
        tk(12);
        chk("release hold", start, 1'b1);
        tk(1);
        chk("release end", start, 1'b0);
        idle();
        $display("release test done");
        setup(32'h1211);
        mv <= 16'h90;
        tk(2);
        mv <= '0;
        tk(1);
        chk("instant release", start, 1'b0);
        mv <= 16'h90;
        tk(2);
        block_pin <= 1'b1;
        tk(1);
        chk("block as drop", {start, blocked}, 2'b01);
        idle();
        setup(32'h1121);
        mv <= 16'h90;
        tk(4);
        mv <= '0;
        tk(1);
        mv <= 16'h90;
        tk(7);
        chk("counter reset at drop", trip, 1'b0);
        tk(1);
        chk("full delay", trip, 1'b1);
        idle();
        setup(32'h2221);
        mv <= 16'h90;
        tk(4);
        mv <= '0;
        tk(6);
        chk("no trip in release", trip, 1'b0);
        mv <= 16'h90;
        tk(1);
        chk("counted in release", trip, 1'b1);
        idle();
        $display("option test done");
        apb(1'b1, A_DIAL, 32'h3);
        apb(1'b1, A_EXPO, 32'hc8);
        setup(32'h1222);
        mv <= 16'h100;
        tk(1);
        chk("power early", {start, trip}, 2'b10);
        tk(1);
        chk("power trip", {start, trip}, 2'b11);
        $display("inverse test done");
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset outputs", {start, trip, blocked, irq}, 4'h0);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_CTRL, 32'h0);
        chk("reset control", rd, 32'h1221);
        tk(7);
        chk("fixed after reset", {start, trip}, 2'b10);
        tk(1);
        chk("trip after reset", {start, trip}, 2'b11);
        $display("reset test done");
        give_verdict();
    end
endmodule
